// ### common/itw_defs.svh
// Constants for the two-wire target write port.
`ifndef ITW_DEFS_SVH
`define ITW_DEFS_SVH
`define ITW_ADDR_LOW      7'h68
`define ITW_ADDR_HIGH     7'h69
`define ITW_BIT_LAST      3'h7
`define ITW_FIFO_DEPTH    4
`define ITW_FIFO_WIDTH    16
`endif

// ### common/itw_pkg.sv
// Types for the two-wire target write port.
package itw_pkg;
    typedef enum logic [2:0] {
        ITW_IDLE,
        ITW_ADDR,
        ITW_ACK,
        ITW_REG,
        ITW_DATA,
        ITW_IGNORE,
        ITW_DONE
    } itw_state_t;
endpackage

// ### logic/itw_target.sv
// Two-wire target write port with its write FIFO.
`timescale 1ns/100ps
`default_nettype none
`include "itw_defs.svh"

// ----------------------------------------------------------------------------
// Write FIFO
// ----------------------------------------------------------------------------
module itw_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rstn,
    // Fill side.
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // Drain side.
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_reg;
    logic [AW-1:0]    rp_reg;
    logic [AW:0]      cnt_reg;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem[rp_reg];

    // Pointers wrap at the depth, which must be a power of two.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                mem[wp_reg] <= in_data;
                wp_reg      <= wp_reg + 1'b1;
            end
            if (pop)
                rp_reg <= rp_reg + 1'b1;
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ----------------------------------------------------------------------------
// Target
// ----------------------------------------------------------------------------
module itw_target
    import itw_pkg::*;
#(
    parameter int FIFO_DEPTH = `ITW_FIFO_DEPTH
) (
    // System.
    input  wire logic        clk,
    input  wire logic        rstn,
    // Strap.
    input  wire logic        addr_select,
    // Serial pins.
    input  wire logic        serial_clock_pin,
    input  wire logic        serial_data_in,
    output logic             serial_data_out,
    output logic             serial_data_oe_n,
    // Register writes.
    output logic             wr_valid,
    output logic [7:0]       wr_addr,
    output logic [7:0]       wr_data,
    input  wire logic        wr_ready,
    // Status.
    output logic             bus_busy
);
    // ------------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------------
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic [1:0] sel_sync_reg;
    logic       scl_d_reg;
    logic       sda_d_reg;

    // Two flops per pin; only the second stage feeds the edge logic.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            scl_sync_reg <= 2'b11;
            sda_sync_reg <= 2'b11;
            sel_sync_reg <= 2'b00;
            scl_d_reg    <= 1'b1;
            sda_d_reg    <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], serial_clock_pin};
            sda_sync_reg <= {sda_sync_reg[0], serial_data_in};
            sel_sync_reg <= {sel_sync_reg[0], addr_select};
            scl_d_reg    <= scl_sync_reg[1];
            sda_d_reg    <= sda_sync_reg[1];
        end
    end

    wire scl       = scl_sync_reg[1];
    wire sda       = sda_sync_reg[1];
    wire scl_rise  = scl && !scl_d_reg;
    wire scl_fall  = !scl && scl_d_reg;
    wire start_det = scl && scl_d_reg && sda_d_reg && !sda;
    wire stop_raw  = scl && scl_d_reg && !sda_d_reg && sda;

    // ------------------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------------------
    itw_state_t state_reg;
    itw_state_t after_ack_reg;
    logic [2:0] bit_reg;
    logic [7:0] shift_reg;
    logic [7:0] regaddr_reg;
    logic       ack_drive_reg;
    logic       toggled_reg;
    logic       busy_reg;
    logic       push_reg;
    logic [7:0] push_data_reg;
    logic       fifo_in_ready;
    logic       fifo_valid;
    logic [15:0] fifo_out;

    // The strap selects the low address bit; 7-bit compare only.
    wire [6:0] own_addr   = sel_sync_reg[1] ? `ITW_ADDR_HIGH : `ITW_ADDR_LOW;
    wire [7:0] byte_in    = {shift_reg[6:0], sda};
    wire       byte_end   = scl_rise && (bit_reg == `ITW_BIT_LAST);
    wire       addr_match = (byte_in[7:1] == own_addr) && !byte_in[0];
    // A stop with no clock toggle since start is ignored.
    wire       stop_det   = stop_raw && toggled_reg;
    // Data byte is acknowledged only if the FIFO can hold it.
    wire       data_ok    = fifo_in_ready && !push_reg;

    // Bit timing comes from sampled edges, so any clock up to 1 MHz works.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_reg     <= ITW_IDLE;
            after_ack_reg <= ITW_IDLE;
            bit_reg       <= 3'h0;
            shift_reg     <= 8'h00;
            regaddr_reg   <= 8'h00;
            ack_drive_reg <= 1'b0;
            toggled_reg   <= 1'b0;
            busy_reg      <= 1'b0;
            push_reg      <= 1'b0;
            push_data_reg <= 8'h00;
        end else begin
            push_reg <= 1'b0;
            if (scl_fall)
                toggled_reg <= 1'b1;
            if (start_det) begin
                state_reg     <= ITW_ADDR;
                bit_reg       <= 3'h0;
                ack_drive_reg <= 1'b0;
                toggled_reg   <= 1'b0;
                busy_reg      <= 1'b1;
            end else if (stop_det) begin
                state_reg     <= ITW_IDLE;
                ack_drive_reg <= 1'b0;
                busy_reg      <= 1'b0;
            end else begin
                case (state_reg)
                    ITW_ADDR, ITW_REG, ITW_DATA: begin
                        if (scl_rise) begin
                            shift_reg <= byte_in;
                            bit_reg   <= bit_reg + 3'h1;
                        end
                        if (byte_end) begin
                            if (state_reg == ITW_ADDR && !addr_match)
                                state_reg <= ITW_IGNORE;
                            else if (state_reg == ITW_DATA && !data_ok)
                                state_reg <= ITW_IGNORE;
                            else begin
                                state_reg <= ITW_ACK;
                                after_ack_reg <= (state_reg == ITW_ADDR) ? ITW_REG :
                                                 (state_reg == ITW_REG)  ? ITW_DATA : ITW_DONE;
                                if (state_reg == ITW_REG)
                                    regaddr_reg <= byte_in;
                                if (state_reg == ITW_DATA) begin
                                    push_reg      <= 1'b1;
                                    push_data_reg <= byte_in;
                                end
                            end
                        end
                    end
                    ITW_ACK: begin
                        // Drive low from the falling edge after bit 8 to the next falling edge.
                        if (scl_fall) begin
                            if (!ack_drive_reg)
                                ack_drive_reg <= 1'b1;
                            else begin
                                ack_drive_reg <= 1'b0;
                                state_reg     <= after_ack_reg;
                            end
                        end
                    end
                    ITW_DONE:   state_reg <= ITW_DONE;
                    ITW_IGNORE: state_reg <= ITW_IGNORE;
                    default:    state_reg <= ITW_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------------------
    // The pin is open drain: only ever pulled low, output enable active low.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            serial_data_out  <= 1'b0;
            serial_data_oe_n <= 1'b1;
            bus_busy         <= 1'b0;
        end else begin
            serial_data_out  <= 1'b0;
            serial_data_oe_n <= !ack_drive_reg;
            bus_busy         <= busy_reg;
        end
    end

    itw_fifo #(
        .WIDTH (`ITW_FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (push_reg),
        .in_data   ({regaddr_reg, push_data_reg}),
        .in_ready  (fifo_in_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_out),
        .out_ready (wr_ready && !wr_valid)
    );

    // Register the FIFO head so the write outputs come from flops.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wr_valid <= 1'b0;
            wr_addr  <= 8'h00;
            wr_data  <= 8'h00;
        end else if (wr_valid) begin
            wr_valid <= 1'b0;
        end else if (fifo_valid && wr_ready) begin
            wr_valid <= 1'b1;
            wr_addr  <= fifo_out[15:8];
            wr_data  <= fifo_out[7:0];
        end
    end
endmodule
`default_nettype wire

// ### testbench/itw_monitor.sv
// Checker of the two-wire target write port.
`timescale 1ns/100ps
`default_nettype none
module itw_monitor #(
    parameter int FIFO_DEPTH = 4
) (
    // System.
    input wire logic       clk,
    input wire logic       rstn,
    // Strap and serial pins.
    input wire logic       addr_select,
    input wire logic       serial_clock_pin,
    input wire logic       serial_data_in,
    input wire logic       serial_data_out,
    input wire logic       serial_data_oe_n,
    // Writes and status.
    input wire logic       wr_valid,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic       wr_ready,
    input wire logic       bus_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Pin and write-port relations.
    chk_ack_in_frame: assert property (!serial_data_oe_n |-> !serial_data_out && bus_busy)
        else $error("data pulled low outside a transfer");
    chk_busy_start: assert property ($fell(serial_data_in) && serial_clock_pin |-> ##[1:8] bus_busy)
        else $error("start did not mark the bus busy");
    chk_busy_end: assert property ($fell(bus_busy) |-> $past(serial_data_in && serial_clock_pin))
        else $error("busy dropped without a stop");
    chk_ack_steady: assert property (serial_clock_pin && $past(serial_clock_pin, 2) |-> $stable(serial_data_oe_n))
        else $error("acknowledge moved while the clock was high");
    chk_ack_length: assert property ($fell(serial_data_oe_n) |-> !serial_data_oe_n [*4])
        else $error("acknowledge shorter than a clock phase");
    chk_write_pulse: assert property (wr_valid |=> !wr_valid)
        else $error("write pulse longer than one cycle");
    chk_write_gate: assert property (wr_valid |-> $past(wr_ready))
        else $error("write presented while the sink was not ready");
    chk_write_hold: assert property (!wr_valid |-> $stable(wr_addr) && $stable(wr_data))
        else $error("write fields moved without a write");
    chk_reset_idle: assert property (disable iff (1'b0) !rstn |=> serial_data_oe_n && !wr_valid && !bus_busy)
        else $error("outputs not idle after reset");
endmodule
bind itw_target itw_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_mon (.clk(clk), .rstn(rstn), .addr_select(addr_select),
    .serial_clock_pin(serial_clock_pin), .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_oe_n(serial_data_oe_n), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_ready(wr_ready), .bus_busy(bus_busy));
`default_nettype wire

// ### testbench/itw_host.sv
// Behavioural two-wire bus controller that drives transfers.
`timescale 1ns/100ps
`default_nettype none
module itw_host (
    // Phase lengths are scaled by slow, so that one model covers several bus rates.
    // System clock paces the bus, four cycles a phase.
    input wire logic  clk,
    // Bus lines; a one on sda_o releases the line.
    input wire logic  sda,
    output var logic  scl_o,
    output var logic  sda_o
);
    int slow = 1;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic hw(input int n);
        repeat (n * slow) @(negedge clk);
    endtask
    // Data falls while the clock is high; works from idle and mid-frame.
    task automatic start();
        sda_o = 1'b1;
        hw(4);
        scl_o = 1'b1;
        hw(4);
        sda_o = 1'b0;
        hw(4);
        scl_o = 1'b0;
    endtask
    // Data changes a cycle after the clock falls, never while it is high.
    task automatic clk_bit(input logic b, output logic s);
        hw(1);
        sda_o = b;
        hw(3);
        scl_o = 1'b1;
        hw(3);
        s = sda;
        hw(1);
        scl_o = 1'b0;
    endtask
    // Eight bits MSB first, then the line is released for the acknowledge.
    task automatic xfer(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) clk_bit(b[i], ack);
        clk_bit(1'b1, ack);
        ack = !ack;
    endtask
    // Data rises while the clock is high.
    task automatic stop();
        hw(1);
        sda_o = 1'b0;
        hw(3);
        scl_o = 1'b1;
        hw(4);
        sda_o = 1'b1;
        hw(8);
    endtask
    // Start then stop with no clock toggle, used only on purpose.
    task automatic bare();
        sda_o = 1'b0;
        hw(4);
        sda_o = 1'b1;
        hw(8);
    endtask
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench of the two-wire target write port.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        addr_select = 1'b0;
    logic        wr_ready = 1'b1;
    logic        scl, sda_h, sd_out, oe_n, wr_valid, bus_busy, s;
    logic [7:0]  wr_addr, wr_data;
    logic [2:0]  a;
    logic [15:0] got[$];
    wire         sda_line;
    int          n_mismatch = 0;
    int          checks = 0;
    int          cycles = 0;
    // The pull-up holds the released data line high.
    assign sda_line = sda_h & (oe_n | sd_out);
    always #50 clk = ~clk;
    itw_host u_host (.clk(clk), .sda(sda_line), .scl_o(scl), .sda_o(sda_h));
    itw_target #(.FIFO_DEPTH(4)) u_dut (.clk(clk), .rstn(rstn), .addr_select(addr_select),
        .serial_clock_pin(scl), .serial_data_in(sda_line), .serial_data_out(sd_out), .serial_data_oe_n(oe_n),
        .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .wr_ready(wr_ready), .bus_busy(bus_busy));
    // Every presented write is kept for later comparison.
    // Sampled on the falling edge, where the registered outputs have settled.
    always @(negedge clk) if (wr_valid === 1'b1) got.push_back({wr_addr, wr_data});
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("%0d comparisons, %0d mismatches", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Whole write frame; the three acknowledges land in a.
    task automatic wr(input logic [7:0] adr, input logic [7:0] r, input logic [7:0] d);
        u_host.start();
        u_host.xfer(adr, a[2]);
        u_host.xfer(r, a[1]);
        u_host.xfer(d, a[0]);
        u_host.stop();
    endtask
    task automatic t_strap();
        wr({7'h68, 1'b0}, 8'h10, 8'h09);
        check(16'(a), 16'h0007);
        check(got.pop_front(), 16'h1009);
        check(16'(bus_busy), 16'h0000);
        addr_select = 1'b1;
        wr({7'h68, 1'b0}, 8'h20, 8'h55);
        check(16'(a), 16'h0000);
        wr({7'h69, 1'b0}, 8'hA5, 8'h3C);
        check(16'(a), 16'h0007);
        check(got.pop_front(), 16'hA53C);
        addr_select = 1'b0;
        wr({7'h68, 1'b1}, 8'h30, 8'h66);
        check(16'(a), 16'h0000);
        check(16'(got.size()), 16'h0000);
        $display("strap and direction test done");
    endtask
    task automatic t_restart();
        u_host.start();
        repeat (4) u_host.clk_bit(1'b1, s);
        check(16'(bus_busy), 16'h0001);
        wr({7'h68, 1'b0}, 8'h44, 8'h81);
        check(16'(a), 16'h0007);
        check(got.pop_front(), 16'h4481);
        u_host.bare();
        check(16'(bus_busy), 16'h0001);
        wr({7'h68, 1'b0}, 8'h7E, 8'h18);
        check(16'(a), 16'h0007);
        check(got.pop_front(), 16'h7E18);
        check(16'(bus_busy), 16'h0000);
        $display("restart test done");
    endtask
    // Sink stalls until the buffer refuses, then drains in order.
    task automatic t_fifo();
        wr_ready = 1'b0;
        for (int i = 0; i < 4; i++) begin
            wr({7'h68, 1'b0}, 8'(i), 8'hC0 + 8'(i));
            check(16'(a), 16'h0007);
        end
        wr({7'h68, 1'b0}, 8'h0F, 8'hEE);
        check(16'(a), 16'h0006);
        check(16'(got.size()), 16'h0000);
        wr_ready = 1'b1;
        repeat (20) @(negedge clk);
        check(16'(got.size()), 16'h0004);
        for (int i = 0; i < 4; i++) check(got.pop_front(), {8'(i), 8'hC0 + 8'(i)});
        $display("buffer test done");
    endtask
    // One write at roughly 96 kHz; the edge logic must not depend on the bus rate.
    task automatic t_speed();
        u_host.slow = 13;
        wr({7'h68, 1'b0}, 8'h5A, 8'hC3);
        u_host.slow = 1;
        check(16'(a), 16'h0007);
        check(got.pop_front(), 16'h5AC3);
        check(16'(bus_busy), 16'h0000);
        $display("bus speed test done");
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        t_strap();
        t_restart();
        t_fifo();
        t_speed();
        print_verdict();
    end
    // Cuts a hung run short; the tests need about 6000 cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
endmodule
`default_nettype wire
